// [common/bridge_cfg_pkg.sv]
/*
  Constants of the bridge configuration header bank: register indices,
  field layouts, reset values and fixed read values.
  Assumes one AHB-Lite slave, one word per register, byte address = 4 * index.
*/
// How it works
// - revision byte, lockable read-write, no fixed reset
// - class code reads 0x06, 0x04, 0x00
// - cache line size stores writes, resets zero
// - upstream latency timer always reads zero
// - header type reads constant 0x01
// - self-test byte reads zero, read-only
// - both base address registers read zero
// - upstream bus number read-write, resets zero
// - downstream bus number read-write, resets zero
// - highest bus number read-write, resets zero
// - downstream latency timer always reads zero
// - io width bit resets one, lockable
// - io base bits 7:4 reset 0xF
// - base and top decide io forwarding
// - top gives bits 15:12, low bits ones
// - top width bit mirrors base width bit
package bridge_cfg_pkg;

  // ------------------------------------------------------------
  // register indices (byte address is four times the index)
  // ------------------------------------------------------------
  localparam logic [7:0] IDX_REVISION = 8'h08;
  localparam logic [7:0] IDX_CLASS_CODE = 8'h09;
  localparam logic [7:0] IDX_CACHE_LINE = 8'h0c;
  localparam logic [7:0] IDX_UP_LATENCY = 8'h0d;
  localparam logic [7:0] IDX_HEADER_TYPE = 8'h0e;
  localparam logic [7:0] IDX_SELF_TEST = 8'h0f;
  localparam logic [7:0] IDX_BASE_ADDR_0 = 8'h10;
  localparam logic [7:0] IDX_BASE_ADDR_1 = 8'h14;
  localparam logic [7:0] IDX_UP_BUS = 8'h18;
  localparam logic [7:0] IDX_DOWN_BUS = 8'h19;
  localparam logic [7:0] IDX_HIGH_BUS = 8'h1a;
  localparam logic [7:0] IDX_DOWN_LATENCY = 8'h1b;
  localparam logic [7:0] IDX_IO_BASE = 8'h1c;
  localparam logic [7:0] IDX_IO_TOP = 8'h1d;
  localparam logic [7:0] IDX_LOCK = 8'h3f;

  // ------------------------------------------------------------
  // fixed read values
  // ------------------------------------------------------------
  localparam logic [7:0] CLASS_INTERFACE = 8'h00;
  localparam logic [7:0] CLASS_SUB = 8'h04;
  localparam logic [7:0] CLASS_BASE = 8'h06;
  localparam logic [7:0] HEADER_TYPE_VAL = 8'h01;
  localparam logic [7:0] SELF_TEST_VAL = 8'h00;
  localparam logic [7:0] LATENCY_VAL = 8'h00;
  localparam logic [31:0] BASE_ADDR_VAL = 32'h0000_0000;

  // ------------------------------------------------------------
  // reset values
  // ------------------------------------------------------------
  localparam logic [7:0] CACHE_LINE_RST = 8'h00;
  localparam logic [7:0] BUS_NUM_RST = 8'h00;
  localparam logic IO_WIDTH_RST = 1'b1;
  localparam logic [3:0] IO_BASE_RST = 4'hf;
  localparam logic [3:0] IO_TOP_RST = 4'h0;
  localparam logic LOCK_RST = 1'b0;

  // ------------------------------------------------------------
  // field layout of the io window bytes
  // ------------------------------------------------------------
  localparam int IO_WIDTH_BIT = 0;
  localparam int IO_ADDR_LSB = 4;
  localparam int IO_ADDR_MSB = 7;
  localparam logic [11:0] IO_LOW_ZERO = 12'h000;
  localparam logic [11:0] IO_LOW_ONES = 12'hfff;

  // ------------------------------------------------------------
  // bus
  // ------------------------------------------------------------
  localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
  localparam logic HRESP_OKAY = 1'b0;

endpackage : bridge_cfg_pkg

// [hdl/bridge_config_header_regs.sv]
/*
  Bridge type 1 configuration header bank, offsets 0x08 to 0x1d, as an
  AHB-Lite slave, plus the io window forwarding decision.
  Assumes a single master, single word transfers, inputs synchronous to CORE_CLK.
*/
// The AHB-Lite slave port is this design's own decision.
`timescale 1ns/100ps
module bridge_config_header_regs #(
  parameter logic [7:0] REVISION_INIT = 8'h00
) (
  // clock and reset
  input wire logic CORE_CLK,
  input wire logic RESETN,
  // ahb-lite slave
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic HREADYOUT,
  output logic [31:0] HRDATA,
  output logic HRESP,
  // io forwarding check
  input wire logic IO_REQ,
  input wire logic [31:0] IO_ADDR,
  output logic IO_DONE,
  output logic IO_FORWARD,
  // register state seen by the rest of the port
  output logic [7:0] UP_BUS_NUMBER,
  output logic [7:0] DOWN_BUS_NUMBER,
  output logic [7:0] HIGH_BUS_NUMBER,
  output logic IO_ADDRESSING_WIDTH
);
  import bridge_cfg_pkg::*;

  typedef enum logic [1:0] {IDLE, WRITE_DATA, READ_WAIT, READ_DATA} phase_e;

  phase_e phase;
  logic [7:0] phase_index;
  logic phase_mapped;

  logic [7:0] revision_number;
  logic [7:0] cache_line_size;
  logic [7:0] upstream_bus_number;
  logic [7:0] downstream_bus_number;
  logic [7:0] highest_bus_number;
  logic io_addressing_width;
  logic [3:0] io_window_base;
  logic [3:0] io_window_top;
  logic config_lock;

  logic accept;
  logic [7:0] addr_index;
  logic addr_mapped;
  logic wr_en;
  logic [7:0] wr_byte;
  logic [31:0] next_hrdata;

  // ------------------------------------------------------------
  // decode helpers
  // ------------------------------------------------------------
  function automatic logic is_mapped(input logic [7:0] idx);
    case (idx)
      IDX_REVISION, IDX_CLASS_CODE, IDX_CACHE_LINE, IDX_UP_LATENCY,
      IDX_HEADER_TYPE, IDX_SELF_TEST, IDX_BASE_ADDR_0, IDX_BASE_ADDR_1,
      IDX_UP_BUS, IDX_DOWN_BUS, IDX_HIGH_BUS, IDX_DOWN_LATENCY,
      IDX_IO_BASE, IDX_IO_TOP, IDX_LOCK: is_mapped = 1'b1;
      default: is_mapped = 1'b0;
    endcase
  endfunction : is_mapped

  function automatic logic write_hits(input logic en, input logic [7:0] idx,
                                      input logic [7:0] target);
    write_hits = en && (idx == target);
  endfunction : write_hits

  // ------------------------------------------------------------
  // ahb-lite address and data phase
  // ------------------------------------------------------------
  // word index from haddr[9:2]; anything above bit 9 is unmapped
  assign addr_index = HADDR[9:2];
  assign addr_mapped = (HADDR[31:10] == 22'h000000) && is_mapped(addr_index);
  assign accept = HSEL && HREADY && (HTRANS == HTRANS_NONSEQ);

  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      phase <= IDLE;
    end else begin
      case (phase)
        READ_WAIT: begin
          phase <= READ_DATA;
        end
        default: begin
          if (accept && HWRITE) begin
            phase <= WRITE_DATA;
          end else if (accept) begin
            phase <= READ_WAIT;
          end else begin
            phase <= IDLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      phase_index <= 8'h00;
      phase_mapped <= 1'b0;
    end else if (accept && (phase != READ_WAIT)) begin
      phase_index <= addr_index;
      phase_mapped <= addr_mapped;
    end
  end

  // one wait state on reads so that a write just before is already stored
  assign HREADYOUT = (phase != READ_WAIT);
  assign HRESP = HRESP_OKAY;

  // only the low byte of each word carries data
  assign wr_en = (phase == WRITE_DATA) && phase_mapped;
  assign wr_byte = HWDATA[7:0];

  // ------------------------------------------------------------
  // writable registers
  // ------------------------------------------------------------
  // lock: once set, lockable fields hold until reset
  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      config_lock <= LOCK_RST;
    end else if (write_hits(wr_en, phase_index, IDX_LOCK) && wr_byte[0]) begin
      config_lock <= 1'b1;
    end
  end

  // revision has no documented reset; a parameter gives a defined start
  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      revision_number <= REVISION_INIT;
    end else if (write_hits(wr_en, phase_index, IDX_REVISION) && !config_lock) begin
      revision_number <= wr_byte;
    end
  end

  // stored for legacy software only; nothing else reads it
  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      cache_line_size <= CACHE_LINE_RST;
    end else if (write_hits(wr_en, phase_index, IDX_CACHE_LINE)) begin
      cache_line_size <= wr_byte;
    end
  end

  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      upstream_bus_number <= BUS_NUM_RST;
    end else if (write_hits(wr_en, phase_index, IDX_UP_BUS)) begin
      upstream_bus_number <= wr_byte;
    end
  end

  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      downstream_bus_number <= BUS_NUM_RST;
    end else if (write_hits(wr_en, phase_index, IDX_DOWN_BUS)) begin
      downstream_bus_number <= wr_byte;
    end
  end

  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      highest_bus_number <= BUS_NUM_RST;
    end else if (write_hits(wr_en, phase_index, IDX_HIGH_BUS)) begin
      highest_bus_number <= wr_byte;
    end
  end

  // io base: bit 0 lockable, bits 3:1 dropped, bits 7:4 always writable
  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      io_addressing_width <= IO_WIDTH_RST;
    end else if (write_hits(wr_en, phase_index, IDX_IO_BASE) && !config_lock) begin
      io_addressing_width <= wr_byte[IO_WIDTH_BIT];
    end
  end

  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      io_window_base <= IO_BASE_RST;
    end else if (write_hits(wr_en, phase_index, IDX_IO_BASE)) begin
      io_window_base <= wr_byte[IO_ADDR_MSB:IO_ADDR_LSB];
    end
  end

  // width bit in this byte is not stored; it mirrors the base byte
  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      io_window_top <= IO_TOP_RST;
    end else if (write_hits(wr_en, phase_index, IDX_IO_TOP)) begin
      io_window_top <= wr_byte[IO_ADDR_MSB:IO_ADDR_LSB];
    end
  end

  // ------------------------------------------------------------
  // read mux
  // ------------------------------------------------------------
  always_comb begin
    next_hrdata = 32'h0000_0000;
    case (phase_index)
      IDX_REVISION: next_hrdata[7:0] = revision_number;
      IDX_CLASS_CODE: next_hrdata[23:0] = {CLASS_BASE, CLASS_SUB, CLASS_INTERFACE};
      IDX_CACHE_LINE: next_hrdata[7:0] = cache_line_size;
      IDX_UP_LATENCY: next_hrdata[7:0] = LATENCY_VAL;
      IDX_HEADER_TYPE: next_hrdata[7:0] = HEADER_TYPE_VAL;
      IDX_SELF_TEST: next_hrdata[7:0] = SELF_TEST_VAL;
      IDX_BASE_ADDR_0, IDX_BASE_ADDR_1: next_hrdata = BASE_ADDR_VAL;
      IDX_UP_BUS: next_hrdata[7:0] = upstream_bus_number;
      IDX_DOWN_BUS: next_hrdata[7:0] = downstream_bus_number;
      IDX_HIGH_BUS: next_hrdata[7:0] = highest_bus_number;
      IDX_DOWN_LATENCY: next_hrdata[7:0] = LATENCY_VAL;
      IDX_IO_BASE: next_hrdata[7:0] = {io_window_base, 3'b000, io_addressing_width};
      IDX_IO_TOP: next_hrdata[7:0] = {io_window_top, 3'b000, io_addressing_width};
      IDX_LOCK: next_hrdata[0] = config_lock;
      default: next_hrdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      HRDATA <= 32'h0000_0000;
    end else if (phase == READ_WAIT) begin
      HRDATA <= phase_mapped ? next_hrdata : 32'h0000_0000;
    end
  end

  // ------------------------------------------------------------
  // io forwarding window
  // ------------------------------------------------------------
  // upper base/limit halves are not held here, so the window lies in the
  // first 64KB in both addressing widths
  logic [15:0] window_low;
  logic [15:0] window_high;
  assign window_low = {io_window_base, IO_LOW_ZERO};
  assign window_high = {io_window_top, IO_LOW_ONES};

  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      IO_DONE <= 1'b0;
      IO_FORWARD <= 1'b0;
    end else begin
      IO_DONE <= IO_REQ;
      IO_FORWARD <= IO_REQ && (IO_ADDR[31:16] == 16'h0000)
                    && (IO_ADDR[15:0] >= window_low)
                    && (IO_ADDR[15:0] <= window_high);
    end
  end

  assign UP_BUS_NUMBER = upstream_bus_number;
  assign DOWN_BUS_NUMBER = downstream_bus_number;
  assign HIGH_BUS_NUMBER = highest_bus_number;
  assign IO_ADDRESSING_WIDTH = io_addressing_width;

endmodule : bridge_config_header_regs

// [verification/bridge_config_header_regs_assertions.sv]
/*
  Concurrent checks on the bridge configuration header bank ports.
  Assumes HREADY is tied to HREADYOUT and one master issuing single words.
*/
`timescale 1ns/100ps
module bridge_config_header_regs_assertions (
  // clock and reset
  input wire logic CORE_CLK,
  input wire logic RESETN,
  // register bus
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  input wire logic HREADYOUT,
  input wire logic [31:0] HRDATA,
  input wire logic HRESP,
  // io window check
  input wire logic IO_REQ,
  input wire logic [31:0] IO_ADDR,
  input wire logic IO_DONE,
  input wire logic IO_FORWARD,
  // register state
  input wire logic [7:0] UP_BUS_NUMBER,
  input wire logic [7:0] DOWN_BUS_NUMBER,
  input wire logic [7:0] HIGH_BUS_NUMBER,
  input wire logic IO_ADDRESSING_WIDTH
);
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!RESETN);

  // ------------------------------------------------------------
  // bus phases
  // ------------------------------------------------------------
  sequence taken(w, a);
    HSEL && HREADY && HTRANS == 2'b10 && HWRITE == w && (HADDR == a || !w);
  endsequence
  sequence wr_done(a);
    taken(1'b1, a) ##1 HREADYOUT;
  endsequence

  a_resp_okay: assert property (HRESP == 1'b0)
    else $error("response not okay");
  a_read_wait: assert property (taken(1'b0, 32'h0) |=> !HREADYOUT ##1 HREADYOUT)
    else $error("read wait state wrong");
  a_up_bus_write: assert property (wr_done(32'h60) |=> UP_BUS_NUMBER == 8'($past(HWDATA)))
    else $error("upstream bus number not stored");
  a_down_bus_write: assert property (wr_done(32'h64) |=> DOWN_BUS_NUMBER == 8'($past(HWDATA)))
    else $error("downstream bus number not stored");
  a_high_bus_write: assert property (wr_done(32'h68) |=> HIGH_BUS_NUMBER == 8'($past(HWDATA)))
    else $error("highest bus number not stored");
  a_io_answer: assert property (IO_REQ |=> IO_DONE)
    else $error("io check not answered");
  a_io_quiet: assert property (!IO_REQ |=> !IO_DONE && !IO_FORWARD)
    else $error("io answer without request");
  a_io_above_64k: assert property (IO_REQ && IO_ADDR[31:16] != 16'h0 |=> !IO_FORWARD)
    else $error("forward above low 64k");
  a_reset_values: assert property ($rose(RESETN) |-> UP_BUS_NUMBER == 8'h00 &&
    DOWN_BUS_NUMBER == 8'h00 && HIGH_BUS_NUMBER == 8'h00 && IO_ADDRESSING_WIDTH)
    else $error("reset values wrong");
endmodule : bridge_config_header_regs_assertions

bind bridge_config_header_regs bridge_config_header_regs_assertions u_chk (
  .CORE_CLK, .RESETN, .HSEL, .HADDR, .HTRANS, .HWRITE, .HWDATA, .HREADY,
  .HREADYOUT, .HRDATA, .HRESP, .IO_REQ, .IO_ADDR, .IO_DONE, .IO_FORWARD,
  .UP_BUS_NUMBER, .DOWN_BUS_NUMBER, .HIGH_BUS_NUMBER, .IO_ADDRESSING_WIDTH
);

// [verification/tb_bridge_config_header_regs.sv]
/*
  Self-checking bench for the bridge configuration header bank.
  Assumes the design answers writes with no wait and reads with one.
*/
`timescale 1ns/100ps
module tb_bridge_config_header_regs;
  localparam logic [7:0] REV = 8'h3c;
  logic CORE_CLK = 1'b0;
  logic RESETN = 1'b0;
  logic HSEL = 1'b1;
  logic [31:0] HADDR = 32'h0;
  logic [1:0] HTRANS = 2'b00;
  logic HWRITE = 1'b0;
  logic [31:0] HWDATA = 32'h0;
  logic IO_REQ = 1'b0;
  logic [31:0] IO_ADDR = 32'h0;
  logic HREADYOUT, HRESP, IO_DONE, IO_FORWARD, IO_ADDRESSING_WIDTH;
  logic [31:0] HRDATA;
  logic [7:0] UP_BUS_NUMBER, DOWN_BUS_NUMBER, HIGH_BUS_NUMBER;
  logic [31:0] q;
  int bad_count = 0;
  int tests_run = 0;
  int cycles = 0;
  // byte address, reset value, fixed bits, writable bits (0x44, 0x80 unmapped)
  logic [31:0] tbl [16][4] = '{
    '{32'h20, {24'h0, REV}, 32'h0, 32'hff}, '{32'h24, 32'h060400, 32'h060400, 32'h0},
    '{32'h30, 32'h0, 32'h0, 32'hff}, '{32'h34, 32'h0, 32'h0, 32'h0},
    '{32'h38, 32'h1, 32'h1, 32'h0}, '{32'h3c, 32'h0, 32'h0, 32'h0},
    '{32'h40, 32'h0, 32'h0, 32'h0}, '{32'h44, 32'h0, 32'h0, 32'h0},
    '{32'h50, 32'h0, 32'h0, 32'h0}, '{32'h60, 32'h0, 32'h0, 32'hff},
    '{32'h64, 32'h0, 32'h0, 32'hff}, '{32'h68, 32'h0, 32'h0, 32'hff},
    '{32'h6c, 32'h0, 32'h0, 32'h0}, '{32'h70, 32'hf1, 32'h0, 32'hf1},
    '{32'h74, 32'h1, 32'h0, 32'hf1}, '{32'h80, 32'h0, 32'h0, 32'h0}};

  bridge_config_header_regs #(.REVISION_INIT(REV)) dut (
    .CORE_CLK, .RESETN, .HSEL, .HADDR, .HTRANS, .HWRITE, .HSIZE(3'b010), .HWDATA,
    .HREADY(HREADYOUT), .HREADYOUT, .HRDATA, .HRESP, .IO_REQ, .IO_ADDR, .IO_DONE,
    .IO_FORWARD, .UP_BUS_NUMBER, .DOWN_BUS_NUMBER, .HIGH_BUS_NUMBER, .IO_ADDRESSING_WIDTH
  );

  initial begin
    forever #12.5 CORE_CLK = ~CORE_CLK;
  end

  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : tally_and_finish

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      $display("ERROR %0t got %h expected %h", $time, got, exp);
      bad_count++;
    end
  endtask : chk

  // hready and read data are taken at the rising edge, before that edge's updates land
  task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
    HTRANS <= 2'b10;
    HADDR <= a;
    HWRITE <= w;
    do @(posedge CORE_CLK); while (HREADYOUT !== 1'b1);
    HTRANS <= 2'b00;
    HWDATA <= d;
    do @(posedge CORE_CLK); while (HREADYOUT !== 1'b1);
    q = HRDATA;
  endtask : xfer

  task automatic rd(input logic [31:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0);
    chk(q, exp);
  endtask : rd

  task automatic io(input logic [31:0] a, input logic exp);
    IO_REQ <= 1'b1;
    IO_ADDR <= a;
    @(posedge CORE_CLK);
    IO_REQ <= 1'b0;
    @(posedge CORE_CLK);
    chk({30'h0, IO_DONE, IO_FORWARD}, {30'h0, 1'b1, exp});
  endtask : io

  task automatic do_reset();
    RESETN <= 1'b0;
    repeat (10) @(posedge CORE_CLK);
    RESETN <= 1'b1;
  endtask : do_reset

  always @(posedge CORE_CLK) begin
    cycles++;
    if (cycles == 4000) begin
      bad_count++;
      tally_and_finish();
    end
  end

  // ------------------------------------------------------------
  // sequence
  // ------------------------------------------------------------
  initial begin
    do_reset();
    for (int i = 0; i < 16; i++) rd(tbl[i][0], tbl[i][1]);
    for (int i = 0; i < 16; i++) xfer(1'b1, tbl[i][0], 32'hffff_ffff);
    for (int i = 0; i < 16; i++) rd(tbl[i][0], tbl[i][2] | tbl[i][3]);
    chk(32'(UP_BUS_NUMBER & DOWN_BUS_NUMBER & HIGH_BUS_NUMBER), 32'hff);
    for (int i = 0; i < 16; i++) xfer(1'b1, tbl[i][0], 32'h5a);
    for (int i = 0; i < 16; i++) rd(tbl[i][0], tbl[i][2] | (32'h5a & tbl[i][3]));
    chk(32'(IO_ADDRESSING_WIDTH), 32'h0);
    // once locked, revision and width bit must hold
    xfer(1'b1, 32'hfc, 32'h1);
    xfer(1'b1, 32'h20, 32'hff);
    xfer(1'b1, 32'h70, 32'hff);
    rd(32'h20, 32'h5a);
    rd(32'h70, 32'hf0);
    xfer(1'b1, 32'h70, 32'h20);
    xfer(1'b1, 32'h74, 32'h40);
    io(32'h1fff, 1'b0);
    io(32'h2000, 1'b1);
    io(32'h4fff, 1'b1);
    io(32'h5000, 1'b0);
    io(32'h1_3000, 1'b0);
    do_reset();
    for (int i = 0; i < 16; i++) rd(tbl[i][0], tbl[i][1]);
    tally_and_finish();
  end
endmodule : tb_bridge_config_header_regs
